//--- rtl/cape_device.sv
// cape_device: config register gate, printer pin remapping, game and ide decode
// assumes: isa cycles held by the host for many clocks; connector pins async
// Functional notes
// - single external mode: drive B moved, pins idle
// - dual external mode: A and B pins idle
// - external modes: fdc inputs ORed with PD4-PD0
// - adapter strobes only on address match, DMA or adapter address write
// - adapter DMA request forwarded to host
// - host DMA acknowledge passed to adapter unchanged
// - host terminal count passed to adapter
// - adapter interrupt level drives IRQ7 through the pin synchroniser
// - software picks adapter mode by mode bits
// - adapter address write pulses both strobes, address out
// - matched I/O drives data, low address, strobe
// - adapter DMA cycles relayed like matched I/O
// - joystick mode drives four control pins high
// - joystick buttons PD5/PD4, paddles PD1/PD0 timed
// - game strobes low on I/O 201H
// - cold reset latches straps into config bits
// - unlock key 89H or 88H chosen by strap
// - index 00H-0BH at 251H, data at 252H
// - non-key write or lock bit relocks access
// - only cold reset restores config registers
// - config 0 bit 7 disables ide port
// - config 0 bit 6 selects ide range
// - mode bits: 01 single, 10 adapter, 11 dual
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cape_device (
   input wire logic clk_in,
   input wire logic rst_n_in,
   cape_isa_if.dev isa,
   input wire logic master_reset_pin_in,
   input wire logic strap_disk_port_disable_in,
   input wire logic strap_disk_port_addr_select_in,
   input wire logic strap_game_key_in,
   input wire logic [7:0] pd_in,
   output logic [7:0] pd_out,
   output logic [7:0] pd_oe_out,
   input wire logic [3:0] spp_ctrl_in,
   output logic strobe_out,
   output logic auto_feed_out,
   output logic select_in_out,
   output logic printer_reset_line_out,
   output logic adapter_write_strobe_out,
   output logic adapter_read_strobe_out,
   output logic [2:0] adapter_addr_low_out,
   input wire logic adapter_dma_request_in,
   input wire logic adapter_irq_in,
   output logic adapter_dma_ack_out,
   output logic adapter_terminal_count_out,
   input wire logic [4:0] fdd_native_in,
   output logic [4:0] fdd_to_fdc_out,
   input wire logic [1:0] fdc_motor_in,
   input wire logic [1:0] fdc_select_in,
   output logic drive_a_motor_out,
   output logic drive_a_select_out,
   output logic drive_b_motor_out,
   output logic drive_b_select_out,
   output logic [3:0] ext_drive_ctrl_out,
   output logic game_read_strobe_out,
   output logic game_write_strobe_out,
   output logic disk_port_cs0_n_out,
   output logic disk_port_cs1_n_out
);
   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   localparam int SYNC_W = 16;
   logic [SYNC_W-1:0] raw_pins;
   logic [SYNC_W-1:0] s1_q;
   logic [SYNC_W-1:0] s2_q;
   logic [SYNC_W-1:0] s3_q;
   logic [SYNC_W-1:0] pins_q;
   assign raw_pins = {fdd_native_in, master_reset_pin_in, adapter_irq_in,
      adapter_dma_request_in, pd_in};
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
               pins_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= raw_pins[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi]) begin
                  pins_q[gi] <= s3_q[gi];
               end
            end
         end
      end
   endgenerate
   logic [7:0] pd_sync;
   logic [4:0] fdd_sync;
   logic cold_reset;
   assign pd_sync = pins_q[7:0];
   assign fdd_sync = pins_q[15:11];
   assign cold_reset = pins_q[10];

   // ----------------------------------------------------------------------
   // configuration registers and access gate
   // ----------------------------------------------------------------------
   logic [7:0] cfg_q [0:cape_pkg::CFG_COUNT-1];
   logic unlocked_q;
   logic [3:0] index_q;
   logic game_key_q;
   logic access_ok;
   logic wr_enable;
   logic wr_index;
   logic wr_data;
   logic index_valid;
   logic [7:0] unlock_key;
   assign unlock_key = game_key_q ? cape_pkg::UNLOCK_KEY_HI : cape_pkg::UNLOCK_KEY_LO;
   assign access_ok = unlocked_q
      & ~cfg_q[cape_pkg::EXTENDED_CONFIG_IDX][cape_pkg::CONFIG_LOCK_BIT];
   assign wr_enable = isa.io_wr & (isa.io_addr == cape_pkg::EXT_FUNC_ENABLE_ADDR);
   assign wr_index = isa.io_wr & (isa.io_addr == cape_pkg::EXT_FUNC_INDEX_ADDR) & access_ok;
   assign wr_data = isa.io_wr & (isa.io_addr == cape_pkg::EXT_FUNC_DATA_ADDR) & access_ok;
   assign index_valid = (index_q <= cape_pkg::CFG_LAST_INDEX);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         unlocked_q <= 1'b0;
      end else if (wr_enable) begin
         unlocked_q <= (isa.io_wdata == unlock_key);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         index_q <= cape_pkg::PORT_ENABLE_CONFIG_IDX;
      end else if (wr_index) begin
         index_q <= isa.io_wdata[3:0];
      end
   end

   // straps are caught while the master reset pin is high, not by rst_n_in
   always_ff @(posedge clk_in) begin
      if (cold_reset) begin
         game_key_q <= strap_game_key_in;
      end
   end

   generate
      for (gi = 0; gi < cape_pkg::CFG_COUNT; gi++) begin : g_cfg
         always_ff @(posedge clk_in) begin
            if (cold_reset) begin
               if (gi == 0) begin
                  cfg_q[gi] <= {strap_disk_port_disable_in, strap_disk_port_addr_select_in,
                                cape_pkg::CR0_LOW_RESET};
               end else begin
                  cfg_q[gi] <= cape_pkg::CFG_RESET;
               end
            end else if (wr_data && index_valid && (index_q == 4'(gi))) begin
               cfg_q[gi] <= isa.io_wdata;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------------
   cape_pkg::cape_mode_e mode;
   logic ext_mode;
   logic adp_mode;
   logic joy_mode;
   logic [7:0] adp_addr;
   assign mode = cape_pkg::cape_mode_e'({
      cfg_q[cape_pkg::EXTENDED_CONFIG_IDX][cape_pkg::UPPER_PORT_MODE_BIT],
      cfg_q[cape_pkg::PORT_ENABLE_CONFIG_IDX][cape_pkg::PORT_MODE_HI_BIT],
      cfg_q[cape_pkg::PORT_ENABLE_CONFIG_IDX][cape_pkg::PORT_MODE_LO_BIT]});
   assign ext_mode = (mode == cape_pkg::CAPE_MODE_EXT_FDD)
      | (mode == cape_pkg::CAPE_MODE_DUAL_FDD);
   assign adp_mode = (mode == cape_pkg::CAPE_MODE_ADAPTER);
   assign joy_mode = (mode == cape_pkg::CAPE_MODE_JOYSTICK);
   assign adp_addr = cfg_q[cape_pkg::ADAPTER_ADDRESS_IDX];

   // ----------------------------------------------------------------------
   // adapter relay
   // ----------------------------------------------------------------------
   logic adp_match;
   logic adp_dma;
   logic adp_wr;
   logic adp_rd;
   logic adp_reset_q;
   assign adp_match = adp_mode & (isa.io_addr[9:3] == adp_addr[6:0]) & ~isa.host_dma_ack;
   assign adp_dma = adp_mode & isa.host_dma_ack;
   assign adp_wr = isa.io_wr & (adp_match | adp_dma);
   assign adp_rd = isa.io_rd & (adp_match | adp_dma);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         adp_reset_q <= 1'b0;
      end else begin
         adp_reset_q <= wr_data & (index_q == cape_pkg::ADAPTER_ADDRESS_IDX);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         adapter_write_strobe_out <= 1'b1;
         adapter_read_strobe_out <= 1'b1;
         adapter_addr_low_out <= 3'h0;
         pd_out <= 8'h00;
         pd_oe_out <= 8'h00;
      end else begin
         adapter_write_strobe_out <= ~(adp_wr | (adp_mode & adp_reset_q));
         adapter_read_strobe_out <= ~(adp_rd | (adp_mode & adp_reset_q));
         adapter_addr_low_out <= adp_mode ? isa.io_addr[2:0] : 3'h0;
         if (adp_mode && adp_reset_q) begin
            pd_out <= adp_addr;
            pd_oe_out <= 8'hFF;
         end else if (adp_wr) begin
            pd_out <= isa.io_wdata;
            pd_oe_out <= 8'hFF;
         end else begin
            pd_out <= 8'h00;
            pd_oe_out <= 8'h00;
         end
      end
   end

   // dma and interrupt pass through the adapter pairs
   assign isa.host_dma_request = adp_mode & pins_q[8];
   assign isa.host_irq7 = adp_mode & pins_q[9];
   assign adapter_dma_ack_out = adp_mode & isa.host_dma_ack;
   assign adapter_terminal_count_out = adp_mode & isa.host_tc;

   // ----------------------------------------------------------------------
   // floppy remapping (drive pins active low, 1 is idle)
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         fdd_to_fdc_out <= 5'h00;
         drive_a_motor_out <= 1'b1;
         drive_a_select_out <= 1'b1;
         drive_b_motor_out <= 1'b1;
         drive_b_select_out <= 1'b1;
         ext_drive_ctrl_out <= 4'hF;
      end else begin
         fdd_to_fdc_out <= ext_mode ? (fdd_sync | pd_sync[4:0]) : fdd_sync;
         drive_a_motor_out <= (mode == cape_pkg::CAPE_MODE_DUAL_FDD) | fdc_motor_in[0];
         drive_a_select_out <= (mode == cape_pkg::CAPE_MODE_DUAL_FDD) | fdc_select_in[0];
         drive_b_motor_out <= ext_mode | fdc_motor_in[1];
         drive_b_select_out <= ext_mode | fdc_select_in[1];
         ext_drive_ctrl_out[1:0] <= (mode == cape_pkg::CAPE_MODE_DUAL_FDD)
            ? {fdc_select_in[0], fdc_motor_in[0]} : 2'b11;
         ext_drive_ctrl_out[3:2] <= ext_mode ? {fdc_select_in[1], fdc_motor_in[1]} : 2'b11;
      end
   end

   // ----------------------------------------------------------------------
   // joystick and game port
   // ----------------------------------------------------------------------
   logic game_rd;
   logic game_wr;
   logic [1:0] paddle_q;
   assign game_rd = isa.io_rd & (isa.io_addr == cape_pkg::GAME_PORT_ADDR);
   assign game_wr = isa.io_wr & (isa.io_addr == cape_pkg::GAME_PORT_ADDR);
   assign game_read_strobe_out = ~game_rd;
   assign game_write_strobe_out = ~game_wr;

   // each one-shot fires on a game port write in joystick mode and ends when its paddle line rises
   generate
      for (gi = 0; gi < 2; gi++) begin : g_paddle
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               paddle_q[gi] <= 1'b0;
            end else if (joy_mode && game_wr) begin
               paddle_q[gi] <= 1'b1;
            end else if (pd_sync[gi]) begin
               paddle_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         strobe_out <= 1'b1;
         auto_feed_out <= 1'b1;
         select_in_out <= 1'b1;
         printer_reset_line_out <= 1'b1;
      end else begin
         strobe_out <= joy_mode | spp_ctrl_in[0];
         auto_feed_out <= joy_mode | spp_ctrl_in[1];
         select_in_out <= joy_mode | spp_ctrl_in[2];
         printer_reset_line_out <= joy_mode | spp_ctrl_in[3];
      end
   end

   // ----------------------------------------------------------------------
   // ide decode
   // ----------------------------------------------------------------------
   logic ide_on;
   logic ide_pri;
   assign ide_on = ~cfg_q[cape_pkg::PORT_ENABLE_CONFIG_IDX][cape_pkg::DISK_PORT_DISABLE_BIT]
      & (isa.io_rd | isa.io_wr) & ~isa.host_dma_ack;
   assign ide_pri = cfg_q[cape_pkg::PORT_ENABLE_CONFIG_IDX][cape_pkg::DISK_PORT_ADDR_SELECT_BIT];
   assign disk_port_cs0_n_out = ~(ide_on & (isa.io_addr[9:3] ==
      (ide_pri ? cape_pkg::IDE_TASK_PRI : cape_pkg::IDE_TASK_SEC)));
   assign disk_port_cs1_n_out = ~(ide_on & (isa.io_addr[9:1] ==
      (ide_pri ? cape_pkg::IDE_CTRL_PRI : cape_pkg::IDE_CTRL_SEC)));

   // ----------------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         isa.io_rdata <= cape_pkg::LOCKED_READ;
      end else if (isa.io_addr == cape_pkg::EXT_FUNC_DATA_ADDR) begin
         isa.io_rdata <= (access_ok && index_valid) ? cfg_q[index_q]
            : cape_pkg::LOCKED_READ;
      end else if (adp_rd) begin
         isa.io_rdata <= pd_sync;
      end else if (joy_mode && isa.io_addr == cape_pkg::GAME_PORT_ADDR) begin
         isa.io_rdata <= {2'b11, pd_sync[5:4], 2'b11, paddle_q};
      end else begin
         isa.io_rdata <= cape_pkg::LOCKED_READ;
      end
   end
endmodule
`default_nettype wire

//--- inc/cape_pkg.sv
// cape_pkg: constants and types shared by the config access and pin remap ends
// assumes: a 10-bit ISA I/O space and one 50 MHz clock on both ends
package cape_pkg;
   // ----------------------------------------------------------------------
   // I/O port addresses
   // ----------------------------------------------------------------------
   localparam logic [9:0] EXT_FUNC_ENABLE_ADDR = 10'h250;
   localparam logic [9:0] EXT_FUNC_INDEX_ADDR = 10'h251;
   localparam logic [9:0] EXT_FUNC_DATA_ADDR = 10'h252;
   localparam logic [9:0] GAME_PORT_ADDR = 10'h201;
   // ide decode, address bits 9:3 for the task file, 9:1 for the control pair
   localparam logic [6:0] IDE_TASK_PRI = 7'h3E;
   localparam logic [6:0] IDE_TASK_SEC = 7'h2E;
   localparam logic [8:0] IDE_CTRL_PRI = 9'h1FB;
   localparam logic [8:0] IDE_CTRL_SEC = 9'h1BB;
   // ----------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------
   localparam logic [7:0] UNLOCK_KEY_HI = 8'h89;
   localparam logic [7:0] UNLOCK_KEY_LO = 8'h88;
   localparam int CFG_COUNT = 12;
   localparam logic [3:0] CFG_LAST_INDEX = 4'hB;
   localparam logic [3:0] PORT_ENABLE_CONFIG_IDX = 4'h0;
   localparam logic [3:0] ADAPTER_ADDRESS_IDX = 4'h2;
   localparam logic [3:0] EXTENDED_CONFIG_IDX = 4'h9;
   localparam int DISK_PORT_DISABLE_BIT = 7;
   localparam int DISK_PORT_ADDR_SELECT_BIT = 6;
   localparam int PORT_MODE_HI_BIT = 3;
   localparam int PORT_MODE_LO_BIT = 2;
   localparam int UPPER_PORT_MODE_BIT = 7;
   localparam int CONFIG_LOCK_BIT = 6;
   localparam logic [5:0] CR0_LOW_RESET = 6'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] LOCKED_READ = 8'hFF;
   // ----------------------------------------------------------------------
   // port modes {upper bit, mode hi, mode lo}
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      CAPE_MODE_NATIVE = 3'b000,
      CAPE_MODE_EXT_FDD = 3'b001,
      CAPE_MODE_ADAPTER = 3'b010,
      CAPE_MODE_DUAL_FDD = 3'b011,
      CAPE_MODE_JOYSTICK = 3'b100,
      CAPE_MODE_EPP = 3'b101,
      CAPE_MODE_ECP = 3'b110,
      CAPE_MODE_ECP_EPP = 3'b111
   } cape_mode_e;
   // ----------------------------------------------------------------------
   // host end: cycle length and avalon word map
   // ----------------------------------------------------------------------
   localparam logic [3:0] IO_CYCLES = 4'h8;
   localparam logic [1:0] AV_ADDR_REG = 2'h0;
   localparam logic [1:0] AV_WDATA_REG = 2'h1;
   localparam logic [1:0] AV_CMD_REG = 2'h2;
   localparam logic [1:0] AV_STATUS_REG = 2'h3;
   localparam int CMD_READ_BIT = 0;
   localparam int CMD_WRITE_BIT = 1;
   localparam int CMD_DMA_ACK_BIT = 2;
   localparam int CMD_TC_BIT = 3;
   typedef enum logic [1:0] {
      CAPE_HOST_IDLE = 2'b00,
      CAPE_HOST_CYCLE = 2'b01,
      CAPE_HOST_DONE = 2'b10
   } cape_host_state_e;
endpackage

//--- inc/cape_isa_if.sv
// cape_isa_if: the host isa bus between the host end and the device end
// assumes: both ends on the same clock; the host holds a cycle several clocks
`timescale 1ns/1ps
`default_nettype none
interface cape_isa_if;
   logic [9:0] io_addr;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   logic io_rd;
   logic io_wr;
   logic host_dma_ack;
   logic host_tc;
   logic host_dma_request;
   logic host_irq7;
   modport dev (
      input io_addr, io_wdata, io_rd, io_wr, host_dma_ack, host_tc,
      output io_rdata, host_dma_request, host_irq7
   );
   modport host (
      output io_addr, io_wdata, io_rd, io_wr, host_dma_ack, host_tc,
      input io_rdata, host_dma_request, host_irq7
   );
endinterface
`default_nettype wire

//--- rtl/cape_host.sv
// cape_host: isa host side, running i/o and dma cycles ordered over avalon-mm
// assumes: software waits on waitrequest; the device answers within a cycle
`timescale 1ns/1ps
`default_nettype none
module cape_host (
   input wire logic clk_in,
   input wire logic rst_n_in,
   cape_isa_if.host isa,
   input wire logic [1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   // ----------------------------------------------------------------------
   // avalon slave
   // ----------------------------------------------------------------------
   cape_pkg::cape_host_state_e state_q;
   logic [3:0] count_q;
   logic [9:0] addr_q;
   logic [7:0] wdata_q;
   logic [7:0] rdata_q;
   logic dma_ack_q;
   logic rvalid_q;
   logic cmd_go;
   logic busy;
   assign busy = (state_q != cape_pkg::CAPE_HOST_IDLE);
   assign cmd_go = avs_write & (avs_address == cape_pkg::AV_CMD_REG) & ~busy;
   assign avs_waitrequest = (avs_read & ~rvalid_q)
      | (avs_write & (avs_address == cape_pkg::AV_CMD_REG) & busy);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rvalid_q <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         rvalid_q <= avs_read & ~rvalid_q;
         case (avs_address)
            cape_pkg::AV_ADDR_REG: avs_readdata <= {22'h00_0000, addr_q};
            cape_pkg::AV_WDATA_REG: avs_readdata <= {24'h00_0000, wdata_q};
            cape_pkg::AV_CMD_REG: avs_readdata <= {29'h0000_0000, dma_ack_q, 2'b00};
            default: avs_readdata <= {16'h0000, rdata_q, 5'h00, isa.host_irq7,
                                      isa.host_dma_request, busy};
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         addr_q <= 10'h000;
         wdata_q <= 8'h00;
      end else if (avs_write && !busy) begin
         if (avs_address == cape_pkg::AV_ADDR_REG) begin
            addr_q <= avs_writedata[9:0];
         end
         if (avs_address == cape_pkg::AV_WDATA_REG) begin
            wdata_q <= avs_writedata[7:0];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         dma_ack_q <= 1'b0;
      end else if (cmd_go) begin
         dma_ack_q <= avs_writedata[cape_pkg::CMD_DMA_ACK_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // isa cycle sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_q <= cape_pkg::CAPE_HOST_IDLE;
         count_q <= 4'h0;
         isa.io_rd <= 1'b0;
         isa.io_wr <= 1'b0;
         isa.host_tc <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         case (state_q)
            cape_pkg::CAPE_HOST_IDLE: begin
               count_q <= 4'h0;
               if (cmd_go && (avs_writedata[cape_pkg::CMD_READ_BIT]
                              ^ avs_writedata[cape_pkg::CMD_WRITE_BIT])) begin
                  isa.io_rd <= avs_writedata[cape_pkg::CMD_READ_BIT];
                  isa.io_wr <= avs_writedata[cape_pkg::CMD_WRITE_BIT];
                  isa.host_tc <= avs_writedata[cape_pkg::CMD_TC_BIT];
                  state_q <= cape_pkg::CAPE_HOST_CYCLE;
               end
            end
            cape_pkg::CAPE_HOST_CYCLE: begin
               count_q <= count_q + 4'h1;
               if (count_q == cape_pkg::IO_CYCLES - 4'h1) begin
                  rdata_q <= isa.io_rd ? isa.io_rdata : rdata_q;
                  isa.io_rd <= 1'b0;
                  isa.io_wr <= 1'b0;
                  isa.host_tc <= 1'b0;
                  state_q <= cape_pkg::CAPE_HOST_DONE;
               end
            end
            cape_pkg::CAPE_HOST_DONE: begin
               state_q <= cape_pkg::CAPE_HOST_IDLE;
            end
            default: begin
               state_q <= cape_pkg::CAPE_HOST_IDLE;
            end
         endcase
      end
   end

   assign isa.io_addr = addr_q;
   assign isa.io_wdata = wdata_q;
   assign isa.host_dma_ack = dma_ack_q;
endmodule
`default_nettype wire

//--- verif/cape_assertions.sv
// cape_assertions: cycle shape checks on the isa bus joining host end and device end
// assumes: instantiated beside the interface, single clock domain
`timescale 1ns/1ps
`default_nettype none
module cape_assertions (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [9:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic host_dma_ack
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   wire logic busy = io_rd | io_wr;
   // ---------------------------------------------------------------
   // bus cycle shape
   // ---------------------------------------------------------------
   rd_wr_excl_a: assert property (!(io_rd && io_wr))
      else $error("read and write together");
   wr_len_a: assert property ($rose(io_wr) |-> io_wr [*8] ##1 !io_wr)
      else $error("write cycle length wrong");
   rd_len_a: assert property ($rose(io_rd) |-> io_rd [*8] ##1 !io_rd)
      else $error("read cycle length wrong");
   addr_hold_a: assert property (busy && $past(busy) |-> $stable(io_addr))
      else $error("address moved in cycle");
   data_hold_a: assert property (io_wr && $past(io_wr) |-> $stable(io_wdata))
      else $error("write data moved in cycle");
   ack_hold_a: assert property (busy && $past(busy) |-> $stable(host_dma_ack))
      else $error("dma ack moved in cycle");
   rd_gap_a: assert property ($rose(io_rd) |-> !$past(io_wr))
      else $error("read started without idle");
   wr_gap_a: assert property ($rose(io_wr) |-> !$past(io_rd))
      else $error("write started without idle");
endmodule
`default_nettype wire

//--- verif/config_access_port_extension_test.sv
// config_access_port_extension_test: host end and device end joined, driven over avalon
// assumes: one 50 MHz clock; connector pins modelled by bench variables
`timescale 1ns/1ps
`default_nettype none
module config_access_port_extension_test;
   logic clk_in = 0, rst_n_in = 0, mr = 0, s7, s6, areq = 0, airq = 0, dk = 0, dack, gk;
   logic [1:0] avs_address = 0, mot, sel;
   logic avs_read = 0, avs_write = 0, avs_waitrequest;
   logic [31:0] avs_writedata = 0, avs_readdata, rd;
   logic [7:0] pd_v, pd_out, pd_oe, r, cr0;
   logic [3:0] spp, ctl, drv;
   logic [4:0] nat, fdc;
   int seed = 64014, error_cnt = 0, n_checks = 0, m;
   wire logic [7:0] pd_w = (pd_oe & pd_out) | (~pd_oe & pd_v);
   cape_isa_if isa_bus ();
   cape_host u_cape_host (.clk_in, .rst_n_in, .isa(isa_bus.host), .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
   cape_device u_cape_device (.clk_in, .rst_n_in, .isa(isa_bus.dev), .master_reset_pin_in(mr),
      .strap_disk_port_disable_in(s7), .strap_disk_port_addr_select_in(s6),
      .strap_game_key_in(gk), .pd_in(pd_w), .pd_out, .pd_oe_out(pd_oe), .spp_ctrl_in(spp),
      .strobe_out(ctl[3]), .auto_feed_out(ctl[2]), .select_in_out(ctl[1]),
      .printer_reset_line_out(ctl[0]), .adapter_write_strobe_out(), .adapter_read_strobe_out(),
      .adapter_addr_low_out(), .adapter_dma_request_in(areq), .adapter_irq_in(airq),
      .adapter_dma_ack_out(dack), .adapter_terminal_count_out(), .fdd_native_in(nat),
      .fdd_to_fdc_out(fdc), .fdc_motor_in(mot), .fdc_select_in(sel),
      .drive_a_motor_out(drv[3]), .drive_a_select_out(drv[2]), .drive_b_motor_out(drv[1]),
      .drive_b_select_out(drv[0]), .ext_drive_ctrl_out(), .game_read_strobe_out(),
      .game_write_strobe_out(), .disk_port_cs0_n_out(), .disk_port_cs1_n_out());
   cape_assertions u_chk (.clk_in, .rst_n_in, .io_addr(isa_bus.io_addr),
      .io_wdata(isa_bus.io_wdata), .io_rd(isa_bus.io_rd), .io_wr(isa_bus.io_wr),
      .host_dma_ack(isa_bus.host_dma_ack));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task report_and_stop();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task tmo();
      error_cnt++;
      $display("BAD %0t wait ran out", $time);
      report_and_stop();
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   task av(input logic [1:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge clk_in);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_in);
         if (avs_waitrequest === 1'b0) break;
      end
      if (i == 50) tmo();
      rd = avs_readdata;
      avs_write <= 0;
      avs_read <= 0;
   endtask
   task io(input logic w, input logic [9:0] a, input logic [7:0] d);
      int k;
      av(0, 1, {22'h0, a});
      av(1, 1, {24'h0, d});
      av(2, 1, {29'h0, dk, w, !w});
      for (k = 0; k < 40; k++) begin
         av(3, 0, 0);
         if (rd[0] === 1'b0) break;
      end
      if (k == 40) tmo();
      r = rd[15:8];
   endtask
   task cfg(input logic [3:0] x, input logic [7:0] d, input logic w);
      io(1, 10'h250, gk ? 8'h89 : 8'h88);
      io(1, 10'h251, {4'h0, x});
      io(w, 10'h252, d);
   endtask
   // ---------------------------------------------------------------
   // stimulus
   // ---------------------------------------------------------------
   initial forever #10 clk_in = ~clk_in;
   initial begin
      repeat (90000) @(posedge clk_in);
      tmo();
   end
   initial begin
      {pd_v, spp, nat, mot, sel, s7, s6, gk} <= 24'($random(seed));
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1;
      mr <= 1;
      repeat (10) @(posedge clk_in);
      mr <= 0;
      areq <= 1;
      airq <= 1;
      repeat (5) @(posedge clk_in);
      cfg(0, 0, 0);
      chk(r, {s7, s6, 6'h00});
      for (m = 0; m < 4; m++) begin
         cr0 = {s7, s6, 2'b00, m[1:0], 2'b00};
         cfg(0, cr0, 1);
         repeat (6) @(posedge clk_in);
         chk(drv, {m == 3, m == 3, m[0], m[0]} | {mot[0], sel[0], mot[1], sel[1]});
         chk(fdc, nat | (m[0] ? pd_v[4:0] : 5'h00));
         chk(ctl, {spp[0], spp[1], spp[2], spp[3]});
         av(3, 0, 0);
         chk(rd[2:1], (m == 2) ? 2'h3 : 2'h0);
         dk = 1;
         av(2, 1, 32'h4);
         @(negedge clk_in);
         chk(dack, m == 2);
         dk = 0;
         av(2, 1, 0);
      end
      rst_n_in <= 0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1;
      cfg(0, 0, 0);
      chk(r, cr0);
      io(1, 10'h250, gk ? 8'h88 : 8'h89);
      io(1, 10'h251, 0);
      io(1, 10'h252, 8'h5A);
      io(0, 10'h252, 0);
      chk(r, 8'hFF);
      cfg(0, 0, 0);
      chk(r, cr0);
      cr0 = {s7, s6, 6'h00};
      cfg(0, cr0, 1);
      cfg(9, 8'h80, 1);
      repeat (2) @(posedge clk_in);
      chk(ctl, 4'hF);
      cfg(9, 8'hC0, 1);
      cfg(0, 0, 0);
      chk(r, 8'hFF);
      report_and_stop();
   end
endmodule
`default_nettype wire
